// [bench/trc_switch.sv]
// external switch model driving the trigger pins
module trc_switch #(
    parameter NUM_PORTS = 4
) (
    // launch clock
    input  wire logic                 aclk,
    // pins towards the block
    output logic      [NUM_PORTS-1:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // contacts open at power-up
    initial pin = '0;
    // move one pin after an edge, then hold for a prompt or slow time
    task automatic flip(input int idx, input logic lvl, input int hold);
        @(posedge aclk);
        pin[idx] <= lvl;
        repeat (hold) @(posedge aclk);
    endtask
endmodule // trc_switch

// [bench/trc_trigger_ctrl_chk.sv]
// concurrent checks on the ports of the trigger control block
module trc_trigger_ctrl_chk #(
    parameter NUM_PORTS    = 4,
    parameter EPOCH_W      = 8,
    parameter NUM_STREAMS  = 3,
    parameter ABORT_CYCLES = 20
) (
    // clock and reset
    input wire logic                   aclk,
    input wire logic                   aresetn,
    // pins
    input wire logic [NUM_PORTS-1:0]   trig_pin,
    // register bus
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic [31:0]            s_axi_rdata,
    // sensor side
    input wire logic                   capture_abort,
    input wire logic                   exposure_start,
    input wire logic [EPOCH_W-1:0]     exposure_epoch,
    input wire logic                   exposure_trig,
    input wire logic                   frame_done,
    input wire logic                   done_trig,
    // routing and alarms
    input wire logic [NUM_STREAMS-1:0] stream_deliver,
    input wire logic                   frame_drop,
    input wire logic                   alarm_event,
    input wire logic                   alarm_image
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [31:0] abt_cnt;
    // cycles since the last abort, cleared at the triggered start
    always @(posedge aclk) begin
        if (!aresetn)
            abt_cnt <= 32'h0;
        else if (capture_abort)
            abt_cnt <= 32'h1;
        else if (exposure_start && exposure_trig)
            abt_cnt <= 32'h0;
        else if (abt_cnt != 32'h0)
            abt_cnt <= abt_cnt + 32'h1;
    end
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_trig_start;
        exposure_start && exposure_trig;
    endsequence
    a_wr_answer: assert property (s_wr_taken |=> ##1 s_axi_bvalid)
        else $error("write response missing");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response missing");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_sync_delay: assert property (capture_abort |->
        $past(trig_pin, 3) != $past(trig_pin, 4)
        || $past(trig_pin, 4) != $past(trig_pin, 5)) else $error("abort unsync");
    a_abort_pulse: assert property (capture_abort |=> !capture_abort)
        else $error("abort longer than a cycle");
    a_alarm_cause: assert property (alarm_event |-> capture_abort)
        else $error("alarm without trigger");
    a_start_time: assert property (s_trig_start |-> abt_cnt == ABORT_CYCLES)
        else $error("triggered start mistimed");
    a_abort_quiet: assert property (abt_cnt != 32'h0
        && abt_cnt < ABORT_CYCLES |-> !exposure_start) else $error("start in abort");
    a_tags_held: assert property (!exposure_start
        |-> $stable(exposure_epoch) && $stable(exposure_trig))
        else $error("exposure tags moved");
    a_route_cause: assert property (stream_deliver != '0 || frame_drop
        || alarm_image |-> $past(frame_done)) else $error("routing without frame");
    a_drop_excl: assert property (frame_drop
        |-> stream_deliver == '0 && !alarm_image) else $error("dropped frame sent");
    a_img_trig: assert property (alarm_image |-> $past(done_trig))
        else $error("alarm image not triggered");
endmodule // trc_trigger_ctrl_chk

// [bench/trc_trigger_ctrl_test.sv]
// self-checking bench for the trigger control block
`include "trc_map.vh"
module trc_trigger_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // signals
    // ****************
    localparam int ABT = 20;
    localparam int FRM = 30;
    localparam int YUV = 50;
    logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, done_epoch = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        frame_done = 1'b0, done_trig = 1'b0;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic   s_axi_rvalid, capture_abort, exposure_start, exposure_trig;
    wire logic   frame_drop, alarm_event, alarm_image;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0]  exposure_epoch, alarm_image_epoch;
    wire logic [2:0]  stream_deliver, stream_still_codec;
    wire logic [3:0]  trig_pin;
    int n_fail = 0, checked = 0, cyc = 0, n_abort = 0;
    // ****************
    // instances
    // ****************
    trc_trigger_ctrl #(.ABORT_CYCLES(ABT), .YUV_CYCLES(YUV)) u_dut (.*);
    trc_switch u_sw (.aclk(aclk), .pin(trig_pin));
    // clock
    always #5 aclk = ~aclk;
    // abort counting and hang limit
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (capture_abort === 1'b1)
            n_abort <= n_abort + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: exp %h got %h", $time, exp, got);
        end
    endtask
    task automatic final_report;
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk({30'h0, er}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(ed, s_axi_rdata);
        chk({30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
    endtask
    // count cycles until the next exposure start
    task automatic to_start(output int n);
        n = 0;
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (exposure_start !== 1'b1 && n < 100);
    endtask
    // accepted edge: abort, alarm, timed triggered start, internal resume
    task automatic t_fire(input int p, input logic lvl, input logic alm,
                          output logic [7:0] ep);
        int n;
        int a0;
        a0 = n_abort;
        u_sw.flip(p, lvl, 0);
        for (n = 0; n < 12 && capture_abort !== 1'b1; n++) begin
            @(posedge aclk);
            #1;
        end
        chk(1, capture_abort);
        chk(alm, alarm_event);
        to_start(n);
        chk(ABT, n);
        chk(1, exposure_trig);
        ep = exposure_epoch;
        to_start(n);
        chk(FRM, n);
        chk(0, exposure_trig);
        chk(a0 + 1, n_abort);
    endtask
    // edge of the wrong direction is ignored
    task automatic t_quiet(input int p, input logic lvl);
        int a0;
        a0 = n_abort;
        u_sw.flip(p, lvl, 12);
        chk(a0, n_abort);
    endtask
    // sensor readout complete, then routing of that frame
    task automatic t_done(input logic [7:0] e, input logic t,
                          input logic [2:0] dl, input logic dr, input logic im);
        @(posedge aclk);
        frame_done <= 1'b1;
        done_epoch <= e;
        done_trig <= t;
        @(posedge aclk);
        frame_done <= 1'b0;
        done_epoch <= ~e;
        done_trig <= ~t;
        #1;
        chk(dl, stream_deliver);
        chk(dr, frame_drop);
        chk(im, alarm_image);
        if (im)
            chk(e, alarm_image_epoch);
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        logic [7:0] ep;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`TRC_OFS_CTRL, `TRC_CTRL_RST, `TRC_RESP_OKAY);
        rd_chk(`TRC_OFS_FRAME_PERIOD, 32'h0032_dcd5, `TRC_RESP_OKAY);
        rd_chk(8'h40, 32'h0, `TRC_RESP_SLVERR);
        wr_chk(8'h40, 32'h1, `TRC_RESP_SLVERR);
        wr_chk(`TRC_OFS_STATUS, 32'hffff_ffff, `TRC_RESP_OKAY);
        wr_chk(`TRC_OFS_CTRL, 32'h1, `TRC_RESP_OKAY);
        wr_chk(`TRC_OFS_PORT_CFG, 32'h0003_0203, `TRC_RESP_OKAY);
        wr_chk(`TRC_OFS_STREAM_CFG, 32'h0004_0207, `TRC_RESP_OKAY);
        wr_chk(`TRC_OFS_FRAME_PERIOD, FRM, `TRC_RESP_OKAY);
        rd_chk(`TRC_OFS_PORT_CFG, 32'h0003_0203, `TRC_RESP_OKAY);
        chk(3'b010, stream_still_codec);
        t_fire(0, 1'b1, 1'b1, ep);
        t_done(ep, 1'b1, 3'b111, 1'b0, 1'b1);
        t_done(ep, 1'b0, 3'b001, 1'b0, 1'b0);
        t_done(ep, 1'b1, 3'b011, 1'b0, 1'b1);
        t_quiet(0, 1'b0);
        t_quiet(1, 1'b1);
        t_fire(1, 1'b0, 1'b1, ep);
        t_done(ep - 8'h1, 1'b0, 3'b000, 1'b1, 1'b0);
        repeat (YUV) @(posedge aclk);
        t_done(ep, 1'b1, 3'b111, 1'b0, 1'b1);
        wr_chk(`TRC_OFS_CTRL, 32'h0, `TRC_RESP_OKAY);
        t_fire(0, 1'b1, 1'b0, ep);
        t_done(ep, 1'b1, 3'b111, 1'b0, 1'b0);
        rd_chk(`TRC_OFS_TRIG_COUNT, 32'h3, `TRC_RESP_OKAY);
        rd_chk(`TRC_OFS_DROP_COUNT, 32'h1, `TRC_RESP_OKAY);
        rd_chk(`TRC_OFS_STATUS, 32'h0000_0300, `TRC_RESP_OKAY);
        final_report;
    end
endmodule // trc_trigger_ctrl_test
bind trc_trigger_ctrl trc_trigger_ctrl_chk #(.ABORT_CYCLES(ABORT_CYCLES)) u_chk (
    .aclk, .aresetn, .trig_pin, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .capture_abort,
    .exposure_start, .exposure_epoch, .exposure_trig, .frame_done, .done_trig,
    .stream_deliver, .frame_drop, .alarm_event, .alarm_image);

// [rtl/trc_map.vh]
// register map, fields, reset values and timing constants of the trigger block
`ifndef TRC_MAP_VH
`define TRC_MAP_VH

// ****************************************
// clock and timing
// ****************************************
`define TRC_CLK_MHZ          100
`define TRC_ABORT_TIME_MS    7
`define TRC_YUV_MAX_FPS      4
`define TRC_FRAME_FPS_DFLT   30
`define TRC_MS_TO_US         1000
`define TRC_HZ_PER_MHZ       1000000

// ****************************************
// register byte offsets
// ****************************************
`define TRC_OFS_CTRL         8'h00
`define TRC_OFS_PORT_CFG     8'h04
`define TRC_OFS_STREAM_CFG   8'h08
`define TRC_OFS_FRAME_PERIOD 8'h0c
`define TRC_OFS_STATUS       8'h10
`define TRC_OFS_TRIG_COUNT   8'h14
`define TRC_OFS_DROP_COUNT   8'h18

// ****************************************
// field positions
// ****************************************
`define TRC_CTRL_ALARM_EN    0
`define TRC_PCFG_TRIG_LSB    0
`define TRC_PCFG_INV_LSB     8
`define TRC_PCFG_DIR_LSB     16
`define TRC_SCFG_EN_LSB      0
`define TRC_SCFG_STILL_LSB   8
`define TRC_SCFG_YUV_LSB     16
`define TRC_STAT_ABORT       0
`define TRC_STAT_EPOCH_LSB   8

// ****************************************
// reset values and bus answers
// ****************************************
`define TRC_CTRL_RST         32'h0000_0000
`define TRC_PCFG_RST         32'h0000_0000
`define TRC_SCFG_RST         32'h0000_0000
`define TRC_RESP_OKAY        2'b00
`define TRC_RESP_SLVERR      2'b10

`endif

// [rtl/trc_trig_in.v]
// one trigger input: two-flop synchroniser, polarity select, edge pulse
module trc_trig_in (
    // clock, reset, enable
    input  wire aclk,
    input  wire aresetn,
    input  wire ce,
    // pin and configuration
    input  wire pin,
    input  wire armed,
    input  wire invert,
    // one pulse per qualifying change
    output reg  edge_pulse
);

    reg sync_a;
    reg sync_b;
    reg last;

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last   <= 1'b0;
        end else if (ce) begin
            sync_a <= pin;
            sync_b <= sync_a;
            last   <= sync_b;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            edge_pulse <= 1'b0;
        end else if (ce) begin
            if (invert) begin
                edge_pulse <= armed & last & ~sync_b;
            end else begin
                edge_pulse <= armed & ~last & sync_b;
            end
        end
    end

endmodule // trc_trig_in

// [rtl/trc_trigger_ctrl.v]
// real-time trigger control: abort, timed exposure, routing, register slave
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`include "trc_map.vh"

// How it works
// - input port with trigger function fires on inactive-to-active change.
// - with invert set, the port fires on active-to-inactive change.
// - any armed port may trigger; edges are OR-ed together.
// - with alarm source enabled, each accepted trigger raises an alarm.
// - alarm e-mail image is the frame captured for that trigger.
// - FTP or card image is the frame captured for that trigger.
// - triggered frames go to every enabled stream, to YUV streams only when the YUV rate limit allows.
// - continuous streams get triggered frames within their normal sequence.
// - still-codec streams carry only triggered frames, as motion JPEG.
// - uncompressed YUV triggered frames limited to four per second.
// - trigger aborts captures; new exposure starts exactly 7 ms later.
// - frames interrupted by an abort are dropped in every stream.
// - internal captures resume one frame period after the abort ends.
module trc_trigger_ctrl #(
    parameter NUM_PORTS    = 4,
    parameter NUM_STREAMS  = 3,
    parameter EPOCH_W      = 8,
    parameter CNT_W        = 32,
    parameter ABORT_CYCLES = `TRC_ABORT_TIME_MS * `TRC_MS_TO_US
                             * `TRC_CLK_MHZ,
    parameter YUV_CYCLES   = (`TRC_CLK_MHZ * `TRC_HZ_PER_MHZ
                             + `TRC_YUV_MAX_FPS - 1) / `TRC_YUV_MAX_FPS,
    parameter FRAME_DFLT   = (`TRC_CLK_MHZ * `TRC_HZ_PER_MHZ)
                             / `TRC_FRAME_FPS_DFLT
) (
    // clock, reset, enable
    input  wire                   aclk,
    input  wire                   aresetn,
    input  wire                   ce,
    // trigger pins
    input  wire [NUM_PORTS-1:0]   trig_pin,
    // axi4-lite write address
    input  wire                   s_axi_awvalid,
    output reg                    s_axi_awready,
    input  wire [7:0]             s_axi_awaddr,
    // axi4-lite write data
    input  wire                   s_axi_wvalid,
    output reg                    s_axi_wready,
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    // axi4-lite write response
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    output reg  [1:0]             s_axi_bresp,
    // axi4-lite read
    input  wire                   s_axi_arvalid,
    output reg                    s_axi_arready,
    input  wire [7:0]             s_axi_araddr,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready,
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    // sensor control
    output reg                    capture_abort,
    output reg                    exposure_start,
    output reg  [EPOCH_W-1:0]     exposure_epoch,
    output reg                    exposure_trig,
    // sensor readout complete
    input  wire                   frame_done,
    input  wire [EPOCH_W-1:0]     done_epoch,
    input  wire                   done_trig,
    // stream routing
    output reg  [NUM_STREAMS-1:0] stream_deliver,
    output reg  [NUM_STREAMS-1:0] stream_still_codec,
    output reg                    frame_drop,
    // alarm events and alarm image
    output reg                    alarm_event,
    output reg                    alarm_image,
    output reg  [EPOCH_W-1:0]     alarm_image_epoch
);

    // ****************************************
    // registers
    // ****************************************
    reg  [31:0]          ctrl;
    reg  [31:0]          port_cfg;
    reg  [31:0]          stream_cfg;
    reg  [CNT_W-1:0]     frame_period;
    reg  [31:0]          trig_count;
    reg  [31:0]          drop_count;

    // trigger and timing state
    wire [NUM_PORTS-1:0] port_edge;
    reg                  aborting;
    reg  [CNT_W-1:0]     abort_cnt;
    reg  [CNT_W-1:0]     frame_cnt;
    reg  [EPOCH_W-1:0]   epoch;
    reg  [CNT_W-1:0]     yuv_gap;
    reg  [NUM_STREAMS-1:0] next_deliver;
    reg                  yuv_used;
    integer              i;
    integer              j;

    // axi write holding
    reg  [7:0]           aw_addr;
    reg                  aw_held;
    reg  [31:0]          w_data;
    reg  [3:0]           w_strb;
    reg                  w_held;

    // ****************************************
    // trigger inputs
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_port
            trc_trig_in u_in (
                .aclk       (aclk),
                .aresetn    (aresetn),
                .ce         (ce),
                .pin        (trig_pin[g]),
                .armed      (port_cfg[`TRC_PCFG_TRIG_LSB + g] &
                             port_cfg[`TRC_PCFG_DIR_LSB + g]),
                .invert     (port_cfg[`TRC_PCFG_INV_LSB + g]),
                .edge_pulse (port_edge[g])
            );
        end
    endgenerate

    wire trig_any = |port_edge;

    // accepted frame: tag matches current epoch
    wire done_ok = frame_done & (done_epoch == epoch);
    wire yuv_ready = (yuv_gap >= YUV_CYCLES[CNT_W-1:0]);

    // ****************************************
    // abort, exposure timing
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            aborting       <= 1'b0;
            abort_cnt      <= {CNT_W{1'b0}};
            frame_cnt      <= {CNT_W{1'b0}};
            epoch          <= {EPOCH_W{1'b0}};
            capture_abort  <= 1'b0;
            exposure_start <= 1'b0;
            exposure_epoch <= {EPOCH_W{1'b0}};
            exposure_trig  <= 1'b0;
            alarm_event    <= 1'b0;
            trig_count     <= 32'h0000_0000;
        end else if (ce) begin
            capture_abort  <= 1'b0;
            exposure_start <= 1'b0;
            alarm_event    <= 1'b0;
            if (trig_any) begin
                capture_abort <= 1'b1;
                aborting      <= 1'b1;
                abort_cnt     <= ABORT_CYCLES[CNT_W-1:0] - 1'b1;
                epoch         <= epoch + 1'b1;
                trig_count    <= trig_count + 1'b1;
                alarm_event   <= ctrl[`TRC_CTRL_ALARM_EN];
            end else if (aborting) begin
                if (abort_cnt == {CNT_W{1'b0}}) begin
                    aborting       <= 1'b0;
                    exposure_start <= 1'b1;
                    exposure_epoch <= epoch;
                    exposure_trig  <= 1'b1;
                    frame_cnt      <= frame_period;
                end else begin
                    abort_cnt <= abort_cnt - 1'b1;
                end
            end else if (frame_cnt <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                // internal timed capture
                exposure_start <= 1'b1;
                exposure_epoch <= epoch;
                exposure_trig  <= 1'b0;
                frame_cnt      <= frame_period;
            end else begin
                frame_cnt <= frame_cnt - 1'b1;
            end
        end
    end

    // ****************************************
    // stream routing
    // ****************************************
    always @* begin
        next_deliver = {NUM_STREAMS{1'b0}};
        yuv_used     = 1'b0;
        for (i = 0; i < NUM_STREAMS; i = i + 1) begin
            if (done_ok && stream_cfg[`TRC_SCFG_EN_LSB + i]) begin
                if (stream_cfg[`TRC_SCFG_YUV_LSB + i]) begin
                    next_deliver[i] = done_trig & yuv_ready;
                    yuv_used = yuv_used | (done_trig & yuv_ready);
                end else if (stream_cfg[`TRC_SCFG_STILL_LSB + i]) begin
                    next_deliver[i] = done_trig;
                end else begin
                    next_deliver[i] = 1'b1;
                end
            end
        end
    end

    // delivery, drop and alarm image pulses
    always @(posedge aclk) begin
        if (!aresetn) begin
            stream_deliver     <= {NUM_STREAMS{1'b0}};
            stream_still_codec <= {NUM_STREAMS{1'b0}};
            frame_drop         <= 1'b0;
            alarm_image        <= 1'b0;
            alarm_image_epoch  <= {EPOCH_W{1'b0}};
            drop_count         <= 32'h0000_0000;
            yuv_gap            <= YUV_CYCLES[CNT_W-1:0];
        end else if (ce) begin
            stream_deliver <= next_deliver;
            stream_still_codec <=
                stream_cfg[`TRC_SCFG_STILL_LSB +: NUM_STREAMS];
            frame_drop <= frame_done & ~done_ok;
            if (frame_done && !done_ok) begin
                drop_count <= drop_count + 1'b1;
            end
            alarm_image <= done_ok & done_trig & ctrl[`TRC_CTRL_ALARM_EN];
            if (done_ok && done_trig) begin
                alarm_image_epoch <= done_epoch;
            end
            if (yuv_used) begin
                yuv_gap <= {CNT_W{1'b0}};
            end else if (!yuv_ready) begin
                yuv_gap <= yuv_gap + 1'b1;
            end
        end
    end

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `TRC_RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            ctrl          <= `TRC_CTRL_RST;
            port_cfg      <= `TRC_PCFG_RST;
            stream_cfg    <= `TRC_SCFG_RST;
            frame_period  <= FRAME_DFLT[CNT_W-1:0];
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr       <= s_axi_awaddr;
                aw_held       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                w_held       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `TRC_RESP_OKAY;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                for (j = 0; j < 4; j = j + 1) begin
                    if (w_strb[j]) begin
                        case (aw_addr)
                            `TRC_OFS_CTRL: begin
                                ctrl[j*8 +: 8] <= w_data[j*8 +: 8];
                            end
                            `TRC_OFS_PORT_CFG: begin
                                port_cfg[j*8 +: 8] <= w_data[j*8 +: 8];
                            end
                            `TRC_OFS_STREAM_CFG: begin
                                stream_cfg[j*8 +: 8] <= w_data[j*8 +: 8];
                            end
                            `TRC_OFS_FRAME_PERIOD: begin
                                frame_period[j*8 +: 8] <= w_data[j*8 +: 8];
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                case (aw_addr)
                    `TRC_OFS_CTRL, `TRC_OFS_PORT_CFG,
                    `TRC_OFS_STREAM_CFG, `TRC_OFS_FRAME_PERIOD,
                    `TRC_OFS_STATUS, `TRC_OFS_TRIG_COUNT,
                    `TRC_OFS_DROP_COUNT: begin
                        s_axi_bresp <= `TRC_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `TRC_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TRC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `TRC_RESP_OKAY;
                case (s_axi_araddr)
                    `TRC_OFS_CTRL:         s_axi_rdata <= ctrl;
                    `TRC_OFS_PORT_CFG:     s_axi_rdata <= port_cfg;
                    `TRC_OFS_STREAM_CFG:   s_axi_rdata <= stream_cfg;
                    `TRC_OFS_FRAME_PERIOD: s_axi_rdata <= frame_period;
                    `TRC_OFS_STATUS: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rdata[`TRC_STAT_ABORT] <= aborting;
                        s_axi_rdata[`TRC_STAT_EPOCH_LSB +: EPOCH_W] <= epoch;
                    end
                    `TRC_OFS_TRIG_COUNT:   s_axi_rdata <= trig_count;
                    `TRC_OFS_DROP_COUNT:   s_axi_rdata <= drop_count;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `TRC_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // trc_trigger_ctrl
